// File: hw/ulmc_defs.svh
`ifndef ULMC_DEFS_SVH
`define ULMC_DEFS_SVH

// ****************************************
// Register offsets on the host port
// ****************************************
`define ULMC_OFS_DATA      3'h0
`define ULMC_OFS_IER       3'h1
`define ULMC_OFS_LFC       3'h3
`define ULMC_OFS_MOC       3'h4
`define ULMC_OFS_LSF       3'h5
`define ULMC_OFS_MIS       3'h6

// ****************************************
// Field positions
// ****************************************
`define ULMC_LFC_STOP      2
`define ULMC_LFC_PAR_EN    3
`define ULMC_LFC_EVEN      4
`define ULMC_LFC_FORCE     5
`define ULMC_LFC_BREAK     6
`define ULMC_LFC_DIV_SEL   7
`define ULMC_MOC_DTR       0
`define ULMC_MOC_RTS       1
`define ULMC_MOC_FLOW_DTR  2
`define ULMC_MOC_AUX       3
`define ULMC_MOC_LOOP      4
`define ULMC_MOC_XON_ANY   5
`define ULMC_MOC_IR        6
`define ULMC_MOC_PRESC     7
`define ULMC_IER_TX        1
`define ULMC_IER_LS        2
`define ULMC_IER_MS        3

// ****************************************
// Reset values
// ****************************************
`define ULMC_LFC_RST       8'h00
`define ULMC_MOC_RST       8'h00
`define ULMC_IER_RST       4'h0
`define ULMC_DIV_RST       8'h00

// ****************************************
// Timing counts
// ****************************************
`define ULMC_PRESC_LAST    2'h3
`define ULMC_IR_TX_TICKS   5'h03
`define ULMC_IR_RX_TICKS   5'h10

`endif

// File: hw/ulmc_pkg.sv
package ulmc_pkg;

    typedef enum logic [2:0]
    {
        ULMC_PAR_NONE  = 3'h0,
        ULMC_PAR_ODD   = 3'h1,
        ULMC_PAR_EVEN  = 3'h2,
        ULMC_PAR_MARK  = 3'h3,
        ULMC_PAR_SPACE = 3'h4
    } ulmc_par_t;

    typedef struct packed
    {
        logic [1:0] word_len;
        logic       stop_long;
        ulmc_par_t  parity;
        logic       brk;
        logic       div_sel;
    } ulmc_fmt_t;

    typedef struct packed
    {
        logic char_done;
        logic par_err;
        logic frm_err;
        logic brk;
    } ulmc_rx_evt_t;

    typedef enum logic
    {
        ULMC_BRK_IDLE = 1'b0,
        ULMC_BRK_SEEN = 1'b1
    } ulmc_brk_st_t;

endpackage

// File: hw/ulmc_line_modem.sv
// What this block does
// - Parity on: even-select picks odd/even; with force, mark if odd-select, else space.
// - Break bit set holds the transmit pin low outside loopback until software clears it.
// - Top format bit switches data offsets to divisor latches; clear by default.
// - Modem bits 0 and 1 drive terminal-ready and request-to-send pins inverted.
// - Modem bit 2 picks terminal-ready/set-ready pairing, only under auto flow.
// - Modem bit 3 has no pin, resets to 0, feeds loopback only.
// - Modem bit 4 set enables internal loopback; cleared by default.
// - Modem bit 5 lets any received character resume halted transmission.
// - Infrared bit loads strap level at any reset; software may overwrite.
// - Infrared mode routes serial paths through encoder/decoder; transmit idles low.
// - Modem bit 7 divides baud generator clock by four; default undivided.
// - Line-status interrupt raised at once for any receive error, when enabled.
// - Reading line status clears overrun, parity, framing and break flags.
// - Line-status bit 0 shows a received character is waiting.
// - Character completing into a full receive store sets overrun, not stored.
// - Parity and framing flags follow the character at the read position.
// - Break flagged after a zero frame; only one break character stored.
// - Holding-empty sets on transfer or empty store, clears on host write.
// - Transmitter-empty only while holding store and shift register are empty.
// - Line-status bit 7 shows an errored character remains stored.
// - Clear-to-send and set-ready changes set delta flags and request interrupt.
// - Ring delta sets only when the ring input rises; may interrupt.
// - Upper modem-status bits are inverted inputs, or control bits in loopback.
`timescale 1ns/1ps
`default_nettype none
`include "ulmc_defs.svh"

module ulmc_line_modem
(
    input  wire logic                   CLK,
    input  wire logic                   NRST,
    input  wire logic                   SOFT_RST,
    input  wire logic [2:0]             HOST_ADDR,
    input  wire logic                   HOST_WR,
    input  wire logic                   HOST_RD,
    input  wire logic [7:0]             HOST_WDATA,
    output var  logic [7:0]             HOST_RDATA,
    output logic                        THR_WR,
    output var  logic [7:0]             THR_WDATA,
    output logic                        RHR_RD,
    input  wire logic [7:0]             RX_DATA,
    input  wire ulmc_pkg::ulmc_rx_evt_t RX_EVT,
    input  wire logic                   RX_FIFO_FULL,
    input  wire logic                   RX_DATA_AVAIL,
    input  wire logic                   RX_HEAD_NEW,
    input  wire logic                   RX_HEAD_PERR,
    input  wire logic                   RX_HEAD_FERR,
    input  wire logic                   RX_HEAD_BRK,
    input  wire logic                   RX_FIFO_ERR_ANY,
    output logic                        RX_PUSH,
    input  wire logic                   FIFO_MODE,
    input  wire logic                   TX_HOLD_XFER,
    input  wire logic                   TX_FIFO_EMPTY,
    input  wire logic                   TX_SHIFT_EMPTY,
    input  wire logic                   TX_SERIAL,
    input  wire logic                   TX_BIT_START,
    input  wire logic                   AUTO_HW_FLOW_EN,
    input  wire logic                   IR_RX_INVERT,
    input  wire logic                   BAUD16_TICK,
    input  wire logic                   IR_STRAP,
    input  wire logic                   RXD,
    input  wire logic                   CTS_N,
    input  wire logic                   DSR_N,
    input  wire logic                   RI_N,
    input  wire logic                   CD_N,
    output var  logic                   TXD,
    output var  logic                   DTR_N,
    output var  logic                   RTS_N,
    output logic                        RX_SERIAL,
    output ulmc_pkg::ulmc_fmt_t         LINE_FMT,
    output logic [15:0]                 DIVISOR,
    output logic                        BAUD_CLK_EN,
    output logic                        FLOW_SEL_DTR,
    output logic                        XON_ANY_RESUME,
    output logic                        LOOPBACK,
    output logic                        IR_MODE,
    output logic                        TX_IRQ,
    output logic                        LS_IRQ,
    output logic                        MS_IRQ
);

    // ****************************************
    // Decode
    // ****************************************
    function automatic logic reg_hit(input logic [2:0] addr, input logic [2:0] ofs);
        reg_hit = (addr == ofs);
    endfunction

    logic                   rst;
    logic [7:0]             lfc_r;
    logic [7:0]             moc_r;
    logic [3:0]             ier_r;
    logic [7:0]             div_lo_r;
    logic [7:0]             div_hi_r;
    logic                   div_sel;
    logic                   loop_on;
    logic                   ir_on;
    logic                   wr_data;
    logic                   wr_ier;
    logic                   wr_lfc;
    logic                   wr_moc;
    logic                   rd_lsf;
    logic                   rd_mis;
    logic [7:0]             lsf;
    logic [7:0]             mis;
    logic [7:0]             rdata_nxt;

    assign rst     = ~NRST | SOFT_RST;
    assign div_sel = lfc_r[`ULMC_LFC_DIV_SEL];
    assign loop_on = moc_r[`ULMC_MOC_LOOP];
    assign ir_on   = moc_r[`ULMC_MOC_IR];
    assign wr_data = HOST_WR & reg_hit(HOST_ADDR, `ULMC_OFS_DATA);
    assign wr_ier  = HOST_WR & reg_hit(HOST_ADDR, `ULMC_OFS_IER);
    assign wr_lfc  = HOST_WR & reg_hit(HOST_ADDR, `ULMC_OFS_LFC);
    assign wr_moc  = HOST_WR & reg_hit(HOST_ADDR, `ULMC_OFS_MOC);
    assign rd_lsf  = HOST_RD & reg_hit(HOST_ADDR, `ULMC_OFS_LSF);
    assign rd_mis  = HOST_RD & reg_hit(HOST_ADDR, `ULMC_OFS_MIS);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // Order: strap, cd, ri, dsr, cts, rxd
    logic [5:0]             pin_s1_r;
    logic [5:0]             pin_s2_r;
    logic                   strap_s;
    logic                   cd_s;
    logic                   ri_s;
    logic                   dsr_s;
    logic                   cts_s;
    logic                   rxd_s;

    always_ff @(posedge CLK)
    begin
        pin_s1_r <= {IR_STRAP, CD_N, RI_N, DSR_N, CTS_N, RXD};
        pin_s2_r <= pin_s1_r;
    end

    assign {strap_s, cd_s, ri_s, dsr_s, cts_s, rxd_s} = pin_s2_r;

    // ****************************************
    // Control registers
    // ****************************************
    always_ff @(posedge CLK)
    begin
        if (rst)
            lfc_r <= `ULMC_LFC_RST;
        else if (wr_lfc)
            lfc_r <= HOST_WDATA;
    end

    // Strap is already synchronised, so taking it during reset is safe
    always_ff @(posedge CLK)
    begin
        if (rst)
        begin
            moc_r                <= `ULMC_MOC_RST;
            moc_r[`ULMC_MOC_IR]  <= strap_s;
        end
        else if (wr_moc)
            moc_r <= HOST_WDATA;
    end

    always_ff @(posedge CLK)
    begin
        if (rst)
            ier_r <= `ULMC_IER_RST;
        else if (wr_ier && !div_sel)
            ier_r <= HOST_WDATA[3:0];
    end

    always_ff @(posedge CLK)
    begin
        if (rst)
        begin
            div_lo_r <= `ULMC_DIV_RST;
            div_hi_r <= `ULMC_DIV_RST;
        end
        else if (div_sel)
        begin
            if (wr_data)
                div_lo_r <= HOST_WDATA;
            if (wr_ier)
                div_hi_r <= HOST_WDATA;
        end
    end

    assign DIVISOR = {div_hi_r, div_lo_r};

    // Data offset goes to the holding registers only while divisors are hidden
    logic                   thr_wr_r;
    logic [7:0]             thr_wdata_r;

    always_ff @(posedge CLK)
    begin
        if (rst)
        begin
            thr_wr_r    <= 1'b0;
            thr_wdata_r <= 8'h00;
        end
        else
        begin
            thr_wr_r <= wr_data & ~div_sel;
            if (wr_data && !div_sel)
                thr_wdata_r <= HOST_WDATA;
        end
    end

    assign THR_WR    = thr_wr_r;
    assign THR_WDATA = thr_wdata_r;
    assign RHR_RD    = HOST_RD & reg_hit(HOST_ADDR, `ULMC_OFS_DATA) & ~div_sel;

    // ****************************************
    // Line format
    // ****************************************
    ulmc_pkg::ulmc_par_t    par_sel;

    always_comb
    begin
        if (!lfc_r[`ULMC_LFC_PAR_EN])
            par_sel = ulmc_pkg::ULMC_PAR_NONE;
        else if (!lfc_r[`ULMC_LFC_FORCE])
            par_sel = lfc_r[`ULMC_LFC_EVEN] ? ulmc_pkg::ULMC_PAR_EVEN
                                            : ulmc_pkg::ULMC_PAR_ODD;
        else
            par_sel = lfc_r[`ULMC_LFC_EVEN] ? ulmc_pkg::ULMC_PAR_SPACE
                                            : ulmc_pkg::ULMC_PAR_MARK;
    end

    assign LINE_FMT.word_len  = lfc_r[1:0];
    assign LINE_FMT.stop_long = lfc_r[`ULMC_LFC_STOP];
    assign LINE_FMT.parity    = par_sel;
    assign LINE_FMT.brk       = lfc_r[`ULMC_LFC_BREAK];
    assign LINE_FMT.div_sel   = div_sel;

    // ****************************************
    // Modem control outputs and modes
    // ****************************************
    // Pins go inactive in loopback so the far end sees nothing of the test
    always_ff @(posedge CLK)
    begin
        if (rst)
        begin
            DTR_N <= 1'b1;
            RTS_N <= 1'b1;
        end
        else
        begin
            DTR_N <= loop_on | ~moc_r[`ULMC_MOC_DTR];
            RTS_N <= loop_on | ~moc_r[`ULMC_MOC_RTS];
        end
    end

    assign FLOW_SEL_DTR   = AUTO_HW_FLOW_EN & moc_r[`ULMC_MOC_FLOW_DTR];
    assign XON_ANY_RESUME = moc_r[`ULMC_MOC_XON_ANY] & RX_EVT.char_done;
    assign LOOPBACK       = loop_on;
    assign IR_MODE        = ir_on;

    // Prescaler: enable every cycle, or every fourth cycle
    logic [1:0]             presc_r;

    always_ff @(posedge CLK)
    begin
        if (rst)
            presc_r <= 2'h0;
        else
            presc_r <= presc_r + 2'h1;
    end

    assign BAUD_CLK_EN = ~moc_r[`ULMC_MOC_PRESC] | (presc_r == `ULMC_PRESC_LAST);

    // ****************************************
    // Infrared encoder and decoder
    // ****************************************
    // A zero bit becomes a short high pulse; the decoder stretches each
    // pulse back into a low bit so the receiver samples it unchanged.
    logic [4:0]             ir_tx_cnt_r;
    logic [4:0]             ir_rx_cnt_r;
    logic                   ir_rx_pulse;

    assign ir_rx_pulse = rxd_s ^ IR_RX_INVERT;

    always_ff @(posedge CLK)
    begin
        if (rst)
            ir_tx_cnt_r <= 5'h00;
        else if (TX_BIT_START && !TX_SERIAL)
            ir_tx_cnt_r <= `ULMC_IR_TX_TICKS;
        else if (BAUD16_TICK && ir_tx_cnt_r != 5'h00)
            ir_tx_cnt_r <= ir_tx_cnt_r - 5'h01;
    end

    always_ff @(posedge CLK)
    begin
        if (rst)
            ir_rx_cnt_r <= 5'h00;
        else if (ir_rx_pulse)
            ir_rx_cnt_r <= `ULMC_IR_RX_TICKS;
        else if (BAUD16_TICK && ir_rx_cnt_r != 5'h00)
            ir_rx_cnt_r <= ir_rx_cnt_r - 5'h01;
    end

    // ****************************************
    // Serial path routing
    // ****************************************
    logic                   txd_nxt;

    always_comb
    begin
        if (loop_on)
            txd_nxt = ~ir_on;
        else if (lfc_r[`ULMC_LFC_BREAK])
            txd_nxt = 1'b0;
        else if (ir_on)
            txd_nxt = (ir_tx_cnt_r != 5'h00);
        else
            txd_nxt = TX_SERIAL;
    end

    always_ff @(posedge CLK)
    begin
        if (rst)
            TXD <= 1'b1;
        else
            TXD <= txd_nxt;
    end

    assign RX_SERIAL = loop_on ? TX_SERIAL
                     : ir_on   ? (ir_rx_cnt_r == 5'h00)
                     : rxd_s;

    // ****************************************
    // Receive status
    // ****************************************
    ulmc_pkg::ulmc_brk_st_t brk_st_r;
    ulmc_pkg::ulmc_brk_st_t brk_st_nxt;
    logic                   brk_dup;
    logic                   overrun_set;
    logic                   oe_r;
    logic                   pe_r;
    logic                   fe_r;
    logic                   bi_r;

    // Later break frames of one long break are dropped until the line idles
    assign brk_dup     = RX_EVT.brk & (brk_st_r == ulmc_pkg::ULMC_BRK_SEEN);
    assign overrun_set = RX_EVT.char_done & RX_FIFO_FULL;
    assign RX_PUSH     = RX_EVT.char_done & ~RX_FIFO_FULL & ~brk_dup;

    always_comb
    begin
        brk_st_nxt = brk_st_r;
        unique case (brk_st_r)
            ulmc_pkg::ULMC_BRK_IDLE:
                if (RX_EVT.char_done && RX_EVT.brk)
                    brk_st_nxt = ulmc_pkg::ULMC_BRK_SEEN;
            ulmc_pkg::ULMC_BRK_SEEN:
                if (RX_SERIAL || (RX_EVT.char_done && !RX_EVT.brk))
                    brk_st_nxt = ulmc_pkg::ULMC_BRK_IDLE;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (rst)
            brk_st_r <= ulmc_pkg::ULMC_BRK_IDLE;
        else
            brk_st_r <= brk_st_nxt;
    end

    // Set beats the read-clear so an error in the read cycle is not lost
    always_ff @(posedge CLK)
    begin
        if (rst)
            oe_r <= 1'b0;
        else if (overrun_set)
            oe_r <= 1'b1;
        else if (rd_lsf)
            oe_r <= 1'b0;
    end

    always_ff @(posedge CLK)
    begin
        if (rst)
        begin
            pe_r <= 1'b0;
            fe_r <= 1'b0;
            bi_r <= 1'b0;
        end
        else if (RX_HEAD_NEW)
        begin
            pe_r <= RX_HEAD_PERR | (pe_r & ~rd_lsf);
            fe_r <= RX_HEAD_FERR | (fe_r & ~rd_lsf);
            bi_r <= RX_HEAD_BRK  | (bi_r & ~rd_lsf);
        end
        else if (rd_lsf)
        begin
            pe_r <= 1'b0;
            fe_r <= 1'b0;
            bi_r <= 1'b0;
        end
    end

    // ****************************************
    // Transmit status
    // ****************************************
    logic                   thre_r;
    logic                   tx_fifo_empty_d_r;
    logic                   thre_set;

    always_ff @(posedge CLK)
    begin
        if (rst)
            tx_fifo_empty_d_r <= 1'b1;
        else
            tx_fifo_empty_d_r <= TX_FIFO_EMPTY;
    end

    assign thre_set = FIFO_MODE ? (TX_FIFO_EMPTY & ~tx_fifo_empty_d_r)
                                : TX_HOLD_XFER;

    always_ff @(posedge CLK)
    begin
        if (rst)
            thre_r <= 1'b1;
        else if (thre_set)
            thre_r <= 1'b1;
        else if (wr_data && !div_sel)
            thre_r <= 1'b0;
    end

    assign lsf = {RX_FIFO_ERR_ANY,
                  thre_r & TX_SHIFT_EMPTY,
                  thre_r,
                  bi_r,
                  fe_r,
                  pe_r,
                  oe_r,
                  RX_DATA_AVAIL};

    assign TX_IRQ = ier_r[`ULMC_IER_TX] & thre_r;
    assign LS_IRQ = ier_r[`ULMC_IER_LS] & ((|lsf[4:1]) | lsf[7]);

    // ****************************************
    // Modem status
    // ****************************************
    logic [3:0]             mlvl;
    logic [3:0]             mlvl_d_r;
    logic                   prime_r;
    logic [3:0]             delta_set;
    logic [3:0]             delta_r;

    // Bits: cd, ri, dsr, cts
    assign mlvl = loop_on ? {moc_r[`ULMC_MOC_AUX], moc_r[`ULMC_MOC_FLOW_DTR],
                             moc_r[`ULMC_MOC_DTR], moc_r[`ULMC_MOC_RTS]}
                          : ~{cd_s, ri_s, dsr_s, cts_s};

    always_ff @(posedge CLK)
    begin
        if (rst)
        begin
            mlvl_d_r <= 4'h0;
            prime_r  <= 1'b0;
        end
        else
        begin
            mlvl_d_r <= mlvl;
            prime_r  <= 1'b1;
        end
    end

    // Priming keeps the first sample after reset from faking a change
    assign delta_set[0] = prime_r & (mlvl[0] ^ mlvl_d_r[0]);
    assign delta_set[1] = prime_r & (mlvl[1] ^ mlvl_d_r[1]);
    assign delta_set[2] = prime_r & mlvl_d_r[2] & ~mlvl[2];
    assign delta_set[3] = prime_r & (mlvl[3] ^ mlvl_d_r[3]);

    always_ff @(posedge CLK)
    begin
        if (rst)
            delta_r <= 4'h0;
        else if (rd_mis)
            delta_r <= delta_set;
        else
            delta_r <= delta_r | delta_set;
    end

    assign mis    = {mlvl, delta_r};
    assign MS_IRQ = ier_r[`ULMC_IER_MS] & (|delta_r);

    // ****************************************
    // Read data
    // ****************************************
    always_comb
    begin
        rdata_nxt = 8'h00;
        if (reg_hit(HOST_ADDR, `ULMC_OFS_DATA))
            rdata_nxt = div_sel ? div_lo_r : RX_DATA;
        else if (reg_hit(HOST_ADDR, `ULMC_OFS_IER))
            rdata_nxt = div_sel ? div_hi_r : {4'h0, ier_r};
        else if (reg_hit(HOST_ADDR, `ULMC_OFS_LFC))
            rdata_nxt = lfc_r;
        else if (reg_hit(HOST_ADDR, `ULMC_OFS_MOC))
            rdata_nxt = moc_r;
        else if (reg_hit(HOST_ADDR, `ULMC_OFS_LSF))
            rdata_nxt = lsf;
        else if (reg_hit(HOST_ADDR, `ULMC_OFS_MIS))
            rdata_nxt = mis;
    end

    always_ff @(posedge CLK)
    begin
        if (rst)
            HOST_RDATA <= 8'h00;
        else if (HOST_RD)
            HOST_RDATA <= rdata_nxt;
    end

endmodule

`default_nettype wire

// File: testbench/ulmc_far_modem.sv
`timescale 1ns/1ps
`default_nettype none
module ulmc_far_modem
(
    input  wire logic       CLK,
    input  wire logic [4:0] WANT_N,
    output var  logic       RXD,
    output var  logic       CD_N,
    output var  logic       RI_N,
    output var  logic       DSR_N,
    output var  logic       CTS_N
);
    // Idle line marks high; pins move just after an edge, never on it
    initial {RXD, CD_N, RI_N, DSR_N, CTS_N} = 5'h1F;
    always @(posedge CLK) {RXD, CD_N, RI_N, DSR_N, CTS_N} <= #1 WANT_N;
endmodule
`default_nettype wire

// File: testbench/ulmc_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ulmc_sva
(
    input wire logic                   CLK,
    input wire logic                   NRST,
    input wire logic                   SOFT_RST,
    input wire logic [2:0]             HOST_ADDR,
    input wire logic                   HOST_WR,
    input wire logic                   HOST_RD,
    input wire logic [7:0]             HOST_WDATA,
    input wire logic                   THR_WR,
    input wire logic [7:0]             THR_WDATA,
    input wire logic                   RHR_RD,
    input wire ulmc_pkg::ulmc_rx_evt_t RX_EVT,
    input wire logic                   RX_FIFO_FULL,
    input wire logic                   RX_PUSH,
    input wire logic                   TXD,
    input wire ulmc_pkg::ulmc_fmt_t    LINE_FMT,
    input wire logic                   BAUD_CLK_EN,
    input wire logic                   XON_ANY_RESUME,
    input wire logic                   LOOPBACK,
    input wire logic                   IR_MODE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST || SOFT_RST);
    sequence s_data_wr;
        HOST_WR && HOST_ADDR == 3'h0;
    endsequence
    a_break_low: assert property ((LINE_FMT.brk && !LOOPBACK && !IR_MODE) [*2] |-> !TXD)
        else $error("break not holding line low");
    a_thr_pass: assert property (s_data_wr ##0 !LINE_FMT.div_sel |=> THR_WR && THR_WDATA == $past(HOST_WDATA))
        else $error("data write not passed on");
    a_div_no_thr: assert property (s_data_wr ##0 LINE_FMT.div_sel |=> !THR_WR)
        else $error("divisor write leaked to transmit");
    a_thr_cause: assert property (THR_WR |-> $past(HOST_WR) && $past(HOST_ADDR) == 3'h0)
        else $error("transmit pulse without cause");
    a_rhr_read: assert property (RHR_RD == (HOST_RD && HOST_ADDR == 3'h0 && !LINE_FMT.div_sel))
        else $error("receive read strobe wrong");
    a_push_full: assert property (RX_PUSH |-> RX_EVT.char_done && !RX_FIFO_FULL)
        else $error("character stored into full store");
    a_presc_gap: assert property (!BAUD_CLK_EN |-> ##[1:3] BAUD_CLK_EN)
        else $error("baud enable gap too long");
    a_xon_cause: assert property (XON_ANY_RESUME |-> RX_EVT.char_done)
        else $error("resume without character");
endmodule
bind ulmc_line_modem ulmc_sva chk (.*);
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic CLK = 0, NRST = 0, SOFT_RST = 0, HOST_WR = 0, HOST_RD = 0, IR_STRAP = 0, FIFO_MODE = 0;
    logic RX_FIFO_FULL = 0, RX_DATA_AVAIL = 0, RX_HEAD_NEW = 0, RX_HEAD_PERR = 0, TX_SERIAL = 1;
    logic RX_HEAD_FERR = 0, RX_HEAD_BRK = 0, RX_FIFO_ERR_ANY = 0, TX_HOLD_XFER = 0;
    logic TX_FIFO_EMPTY = 1, TX_SHIFT_EMPTY = 1, TX_BIT_START = 0, AUTO_HW_FLOW_EN = 0;
    logic IR_RX_INVERT = 0, BAUD16_TICK = 0, THR_WR, RHR_RD, RX_PUSH, TXD, DTR_N, RTS_N;
    logic RX_SERIAL, BAUD_CLK_EN, LOOPBACK, FLOW_SEL_DTR, XON_ANY_RESUME, IR_MODE;
    logic TX_IRQ, LS_IRQ, MS_IRQ;
    wire  RXD, CTS_N, DSR_N, RI_N, CD_N;
    logic [2:0]  HOST_ADDR = 0;
    logic [4:0]  WANT_N = 5'h1F;
    logic [7:0]  HOST_WDATA = 0, RX_DATA = 8'h5C, HOST_RDATA, THR_WDATA;
    logic [15:0] DIVISOR;
    ulmc_pkg::ulmc_rx_evt_t RX_EVT = '0;
    ulmc_pkg::ulmc_fmt_t    LINE_FMT;
    int   miscompares = 0, num_checks = 0, cyc = 0, i, n;
    ulmc_line_modem dut (.*);
    ulmc_far_modem  far (.*);
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        miscompares += (g !== e);
        if (g !== e) $display("FAIL %s expected %h seen %h", nm, e, g);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge CLK) #1 {HOST_WR, HOST_ADDR, HOST_WDATA} = {1'b1, a, d};
        @(posedge CLK) #1 HOST_WR = 0;
    endtask
    task automatic rc(input string nm, input logic [2:0] a, input logic [7:0] e,
                      input logic [7:0] m = 8'hFF);
        @(posedge CLK) #1 {HOST_RD, HOST_ADDR} = {1'b1, a};
        @(posedge CLK) #1 HOST_RD = 0;
        chk(nm, e, HOST_RDATA & m);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial forever #20 CLK = ~CLK;
    // Tick sources keep the encoder and decoder logic alive; cycle cap cuts a hang
    always @(posedge CLK)
    begin
        cyc <= cyc + 1;
        {BAUD16_TICK, TX_BIT_START} <= #1 {2{cyc[3:0] == 4'h0}};
        miscompares += (cyc == 3000);
        if (cyc == 3000) complete_run();
    end
    initial
    begin
        // Three edges so the strap passes its sync flops
        repeat (3) @(posedge CLK);
        #1 NRST = 1;
        rc("fmt", 3, 8'h00);
        rc("modem", 4, 8'h00);
        rc("line", 5, 8'h60);
        rc("unmapped", 2, 8'h00);
        for (i = 0; i < 8; i++)
        begin
            wr(3, 8'(i << 3));
            n = !i[0] ? 0 : i[2] ? 3 + i[1] : 1 + i[1];
            chk("parity", 16'(n), 16'(LINE_FMT.parity));
        end
        wr(3, 8'h40);
        repeat (4) @(posedge CLK) #1 chk("break", 0, TXD);
        wr(3, 8'h80);
        wr(0, 8'hA5);
        wr(1, 8'h3C);
        chk("divisor", 16'h3CA5, DIVISOR);
        wr(3, 8'h00);
        @(posedge CLK) #1 chk("idle", 1, TXD);
        rc("rx data", 0, 8'h5C);
        $display("test format done");
        wr(1, 8'h0E);
        wr(0, 8'h5A);
        @(posedge CLK) #1 chk("thr data", 8'h5A, THR_WDATA);
        chk("tx irq", 0, TX_IRQ);
        rc("thr full", 5, 8'h00);
        @(posedge CLK) #1 TX_HOLD_XFER = 1;
        @(posedge CLK) #1 TX_HOLD_XFER = 0;
        chk("tx irq", 1, TX_IRQ);
        $display("test transmit done");
        wr(4, 8'h03);
        @(posedge CLK) #1 chk("pins", 0, {DTR_N, RTS_N});
        AUTO_HW_FLOW_EN = 1;
        wr(4, 8'h1F);
        @(posedge CLK) #1 chk("loop pins", 3, {DTR_N, RTS_N});
        chk("flow", 1, FLOW_SEL_DTR);
        rc("loop lv", 6, 8'hF0, 8'hF0);
        AUTO_HW_FLOW_EN = 0;
        wr(4, 8'h00);
        chk("flow", 0, FLOW_SEL_DTR);
        repeat (4) @(posedge CLK);
        rc("ms clr", 6, 8'h0F);
        for (i = 0; i < 3; i++)
        begin
            WANT_N = i == 1 ? 5'h1A : 5'h1E;
            repeat (5) @(posedge CLK);
            #1 chk("ms irq", i != 1, MS_IRQ);
            rc("deltas", 6, i == 0 ? 8'h11 : i == 1 ? 8'h50 : 8'h14);
        end
        rc("clr", 6, 8'h10);
        $display("test modem done");
        wr(4, 8'h20);
        {RX_DATA_AVAIL, RX_FIFO_ERR_ANY} = 2'b11;
        @(posedge CLK) #1 {RX_EVT, RX_FIFO_FULL, RX_HEAD_NEW, RX_HEAD_PERR} = 7'h47;
        {RX_HEAD_FERR, RX_HEAD_BRK} = 2'b11;
        #1 chk("xon push", 2, {XON_ANY_RESUME, RX_PUSH});
        @(posedge CLK) #1 {RX_EVT, RX_HEAD_NEW, RX_HEAD_PERR, RX_HEAD_FERR, RX_HEAD_BRK} = '0;
        chk("ls irq", 1, LS_IRQ);
        rc("errs", 5, 8'hFF);
        rc("clr", 5, 8'hE1);
        $display("test receive done");
        wr(4, 8'h80);
        n = 0;
        repeat (8) @(posedge CLK) #1 n += BAUD_CLK_EN;
        chk("presc", 2, 16'(n));
        {IR_STRAP, SOFT_RST} = 2'b11;
        repeat (3) @(posedge CLK);
        #1 SOFT_RST = 0;
        rc("strap", 4, 8'h40);
        @(posedge CLK) #1 chk("ir idle", 0, {IR_MODE, TXD} ^ 2'b10);
        wr(4, 8'h00);
        chk("ir", 0, IR_MODE);
        $display("test control done");
        complete_run();
    end
endmodule
`default_nettype wire
